// ---- enclave_debug_trace_gating.sv ----
// enclave debug, branch trace and counter gating for one thread
`timescale 1ns/10ps
module enclave_debug_trace_gating
  import enclave_gate_pkg::*;
(
  input wire logic sys_clk, // core clock, 100 MHz
  input wire logic srst, // synchronous reset, active high
  // apb slave
  input wire logic psel, // slave select
  input wire logic penable, // access phase
  input wire logic pwrite, // write when high
  input wire logic [7:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  output logic [31:0] prdata, // read data
  output logic pready, // transfer done
  output logic pslverr, // unmapped address
  // enclave transitions, one-cycle pulses
  input wire logic entry_valid, // enter or resume retired
  input wire logic entry_is_resume, // entry used the resume op
  input wire logic debug_opt_in_flag, // flag of the control structure
  input wire logic [63:0] entry_ip, // address of entry instruction
  input wire logic [63:0] entry_dest, // entry destination
  input wire logic sync_exit_valid, // enclave_sync_exit retired
  input wire logic [63:0] sync_exit_ip, // address of exit instruction
  input wire logic [63:0] sync_exit_dest, // exit destination
  input wire logic async_exit_valid, // enclave_async_exit done
  input wire logic [63:0] state_save_ip, // ip saved in state_save_area
  input wire logic [63:0] landing_point, // async_exit_landing_point
  input wire logic event_pushes_rec, // causing event records a branch
  input wire logic [63:0] event_target, // causing event destination
  input wire logic branch_valid, // branch retired inside enclave
  input wire logic [63:0] branch_src, // branch source
  input wire logic [63:0] branch_dst, // branch target
  // data accesses of enclave ops
  input wire logic access_valid, // access checked this cycle
  input wire logic access_implicit, // implicit access by the op
  input wire logic access_protected, // operand in protected memory
  input wire leaf_t access_leaf, // which leaf made it
  input wire logic access_raw_hit, // raw breakpoint address match
  // trap opcodes
  input wire logic opcode_valid, // opcode retired inside enclave
  input wire logic [7:0] opcode, // its first byte
  input wire logic [63:0] opcode_ip, // its address
  input wire logic sibling_opt_out, // other thread runs opt-out
  // outputs
  output logic bp_match, // data breakpoint match
  output trap_rep_t trap_rep, // fault report for the trap opcodes
  output logic single_step_trap, // branch single-step trap
  output branch_rec_t branch_rec, // record to push
  output logic fixed0_run, // fixed_counter_zero may count
  output logic pmc_run, // programmable_counter may count
  output logic precise_event_sampling_run, // precise_event_sampling may record
  output logic fixed12_run, // cycle counters may count
  output logic own_opt_out, // tells sibling we run opt-out
  output logic [SIB_CNT-1:0] count_both_threads // effective qualifiers
);

  logic [31:0] ctrl_q;
  logic [SIB_CNT-1:0] sib_cfg_q;
  logic side_channel_interference_flag_q;
  logic in_encl_q;
  logic opt_in_q;
  logic lbr_at_entry_q;
  logic [63:0] entry_ip_q;
  seq_t seq_q;
  seq_t seq_d;
  logic [63:0] evt_target_q;
  logic [63:0] landing_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic bp_q;
  trap_rep_t trap_q;
  logic sstep_q;
  branch_rec_t rec_q;
  branch_rec_t rec_d;
  logic suppress_q;
  logic run_q;
  logic [SIB_CNT-1:0] both_q;
  logic map_is_trap;
  logic [7:0] map_vector;
  logic any_exit;
  logic wr_en;
  logic rd_en;
  logic far_ok;
  logic lbr_en;

  // registered output drive, fixed12_run tied high
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign bp_match = bp_q;
  assign trap_rep = trap_q;
  assign single_step_trap = sstep_q;
  assign branch_rec = rec_q;
  assign fixed0_run = run_q;
  assign pmc_run = run_q;
  assign precise_event_sampling_run = run_q;
  assign fixed12_run = 1'b1;
  assign own_opt_out = suppress_q;
  assign count_both_threads = both_q;

  // true when the register address is mapped
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == CTRL_OFS) || (a == STATE_OFS) ||
      (a == PERF_HI_OFS) || (a == SIB_CFG_OFS);
  endfunction

  // build an enclave-op record: predicted and non-transactional
  function automatic branch_rec_t encl_rec(input logic [63:0] s,
                                           input logic [63:0] d);
    branch_rec_t r;
    r.valid = 1'b1;
    r.non_tx = 1'b1;
    r.src = s;
    r.src[PRED_BIT] = 1'b1;
    r.dst = d;
    encl_rec = r;
  endfunction

  assign any_exit = sync_exit_valid | async_exit_valid;
  // pready rises in the second access cycle, so every access takes two
  assign wr_en = psel & penable & pwrite & pready_q;
  assign rd_en = psel & penable & ~pwrite & ~pready_q;
  assign lbr_en = ctrl_q[CTRL_LBR_BIT];
  // far filter: a set filter bit drops enclave transition records
  assign far_ok = ~ctrl_q[CTRL_FAR_FILTER_BIT];

  trap_opcode_map u_map (
    .opcode(opcode),
    .opt_in(opt_in_q),
    .is_trap(map_is_trap),
    .vector(map_vector)
  );

  // apb handshake, one wait state then a one-cycle pready
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~addr_hit(paddr);
    end
  end

  // read data captured on the same edge that raises pready
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        CTRL_OFS: prdata_q <= ctrl_q;
        STATE_OFS: prdata_q <= {29'h0000_0000, suppress_q, opt_in_q,
                                in_encl_q};
        PERF_HI_OFS: prdata_q <= {3'h0, side_channel_interference_flag_q,
                                  28'h000_0000};
        SIB_CFG_OFS: prdata_q <= {28'h000_0000, sib_cfg_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // software configuration registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET;
      sib_cfg_q <= SIB_RESET;
    end else if (wr_en && paddr == CTRL_OFS) begin
      ctrl_q <= pwdata & CTRL_MASK;
    end else if (wr_en && paddr == SIB_CFG_OFS) begin
      sib_cfg_q <= pwdata[SIB_CNT-1:0];
    end
  end

  // interference flag: opt-out entry sets, write-one clears, set wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      side_channel_interference_flag_q <= 1'b0;
    end else if (entry_valid && !debug_opt_in_flag) begin
      side_channel_interference_flag_q <= 1'b1;
    end else if (wr_en && paddr == PERF_HI_OFS &&
                 pwdata[PERF_FLAG_BIT]) begin
      side_channel_interference_flag_q <= 1'b0;
    end
  end

  // entry class latched; an exit in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      in_encl_q <= 1'b0;
      opt_in_q <= 1'b0;
      lbr_at_entry_q <= 1'b0;
      entry_ip_q <= 64'h0000_0000_0000_0000;
    end else if (any_exit) begin
      in_encl_q <= 1'b0;
      opt_in_q <= 1'b0;
    end else if (entry_valid) begin
      in_encl_q <= 1'b1;
      opt_in_q <= debug_opt_in_flag;
      lbr_at_entry_q <= lbr_en;
      entry_ip_q <= entry_ip;
    end
  end

  // data breakpoint gating per leaf and operand location
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bp_q <= 1'b0;
    end else begin
      bp_q <= access_valid & access_raw_hit &
        (~access_protected |
         (~access_implicit & in_encl_q & opt_in_q &
          (access_leaf == LEAF_KEY || access_leaf == LEAF_REPORT)));
    end
  end

  // trap opcodes become faults with zero length
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trap_q <= '0;
    end else begin
      trap_q.valid <= opcode_valid & in_encl_q & map_is_trap;
      trap_q.vector <= map_vector;
      trap_q.evt_type <= EVT_HW_EXCEPTION;
      trap_q.insn_len <= INSN_LEN_ZERO;
      trap_q.ssa_ip <= opcode_ip;
      trap_q.stack_ip <= landing_point;
    end
  end

  // branch single-step: opt-in enter and sync exits only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sstep_q <= 1'b0;
    end else begin
      sstep_q <= ctrl_q[CTRL_SSTEP_BIT] &
        ((entry_valid & ~entry_is_resume & debug_opt_in_flag) |
         sync_exit_valid);
    end
  end

  // second record of an opt-out async exit waits one cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      seq_q <= SEQ_IDLE;
      evt_target_q <= 64'h0000_0000_0000_0000;
      landing_q <= 64'h0000_0000_0000_0000;
    end else begin
      seq_q <= seq_d;
      if (async_exit_valid) begin
        evt_target_q <= event_target;
        landing_q <= landing_point;
      end
    end
  end

  // record selection; the core spaces exits so the second push is free
  always_comb begin
    seq_d = SEQ_IDLE;
    rec_d = '0;
    case (seq_q)
      SEQ_EVENT: begin
        // event record now sourced at the landing point
        rec_d.valid = 1'b1;
        rec_d.src = landing_q;
        rec_d.dst = evt_target_q;
      end
      SEQ_IDLE: begin
        if (async_exit_valid && in_encl_q && opt_in_q && lbr_en) begin
          rec_d = encl_rec(state_save_ip, landing_point);
        end else if (async_exit_valid && in_encl_q && !opt_in_q &&
                     lbr_at_entry_q) begin
          rec_d = encl_rec(entry_ip_q, landing_point);
          seq_d = event_pushes_rec ? SEQ_EVENT : SEQ_IDLE;
        end else if (sync_exit_valid && in_encl_q && opt_in_q && lbr_en) begin
          rec_d = encl_rec(sync_exit_ip, sync_exit_dest);
        end else if (sync_exit_valid && in_encl_q && !opt_in_q &&
                     lbr_at_entry_q) begin
          // single record for the whole opt-out stay
          rec_d = encl_rec(entry_ip_q, sync_exit_dest);
        end else if (entry_valid && debug_opt_in_flag && lbr_en) begin
          rec_d = encl_rec(entry_ip, entry_dest);
        end else if (branch_valid && in_encl_q && opt_in_q && lbr_en) begin
          rec_d.valid = 1'b1;
          rec_d.src = branch_src;
          rec_d.dst = branch_dst;
        end
        // transition records obey the far filter
        if (rec_d.non_tx && !far_ok) begin
          rec_d.valid = 1'b0;
        end
      end
      default: begin
        seq_d = SEQ_IDLE;
      end
    endcase
  end

  // branch record output register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rec_q <= '0;
    end else begin
      rec_q <= rec_d;
    end
  end

  // opt-out entry stops thread counters, any exit resumes them
  // run enable kept in its own flop so the outputs need no inverter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      suppress_q <= 1'b0;
      run_q <= 1'b1;
    end else if (any_exit) begin
      suppress_q <= 1'b0;
      run_q <= 1'b1;
    end else if (entry_valid) begin
      suppress_q <= ~debug_opt_in_flag;
      run_q <= debug_opt_in_flag;
    end
  end

  // demote both-threads counters while sibling runs opt-out
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      both_q <= SIB_RESET;
    end else begin
      both_q <= sib_cfg_q & {SIB_CNT{~sibling_opt_out}};
    end
  end

  // a_class_latch
  a_class_latch: assert property (@(posedge sys_clk) disable iff (srst)
    entry_valid && !any_exit |=>
    in_encl_q && opt_in_q == $past(debug_opt_in_flag))
    else $error("entry class not latched");
  // a_bp_protected
  a_bp_protected: assert property (@(posedge sys_clk) disable iff (srst)
    access_valid && access_protected &&
    (access_leaf == LEAF_MGMT || access_leaf == LEAF_ENTER) |=> !bp_q)
    else $error("management leaf matched on protected operand");
  // a_bp_outside
  a_bp_outside: assert property (@(posedge sys_clk) disable iff (srst)
    access_valid && access_raw_hit && !access_protected |=> bp_q)
    else $error("outside operand did not match");
  // a_trap_optout
  a_trap_optout: assert property (@(posedge sys_clk) disable iff (srst)
    opcode_valid && in_encl_q && !opt_in_q && map_is_trap |=>
    trap_q.valid && trap_q.vector == VEC_INVALID_OP)
    else $error("opt-out trap not invalid opcode");
  // a_trap_report
  a_trap_report: assert property (@(posedge sys_clk) disable iff (srst)
    trap_q.valid |-> trap_q.evt_type == EVT_HW_EXCEPTION &&
    trap_q.insn_len == INSN_LEN_ZERO && trap_q.ssa_ip == $past(opcode_ip))
    else $error("trap report fields wrong");
  // a_sstep_resume
  a_sstep_resume: assert property (@(posedge sys_clk) disable iff (srst)
    entry_valid && entry_is_resume && !sync_exit_valid |=> !sstep_q)
    else $error("single-step after resume");
  // a_rec_order
  a_rec_order: assert property (@(posedge sys_clk) disable iff (srst)
    seq_q == SEQ_EVENT |-> rec_q.valid && rec_q.dst == landing_q ##1
    rec_q.valid && rec_q.src == landing_q)
    else $error("opt-out async records out of order");
  // a_rec_pred
  a_rec_pred: assert property (@(posedge sys_clk) disable iff (srst)
    rec_q.valid && rec_q.non_tx |-> rec_q.src[PRED_BIT])
    else $error("enclave record not predicted");
  // a_flag_set
  a_flag_set: assert property (@(posedge sys_clk) disable iff (srst)
    entry_valid && !debug_opt_in_flag |=> side_channel_interference_flag_q)
    else $error("interference flag not set");
  // a_count_resume
  a_count_resume: assert property (@(posedge sys_clk) disable iff (srst)
    suppress_q && any_exit |=> fixed0_run && pmc_run && precise_event_sampling_run)
    else $error("counters not resumed after exit");

  c_optout_stay: cover property (@(posedge sys_clk) disable iff (srst)
    entry_valid && !debug_opt_in_flag ##[1:20] async_exit_valid);
  c_optin_trap: cover property (@(posedge sys_clk) disable iff (srst)
    trap_q.valid && trap_q.vector == VEC_BREAKPOINT);
  c_two_records: cover property (@(posedge sys_clk) disable iff (srst)
    seq_q == SEQ_EVENT);

endmodule // enclave_debug_trace_gating

// ---- enclave_gate_pkg.sv ----
// shared constants and types for the enclave debug and trace gating block
package enclave_gate_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATE_OFS = 8'h04;
  localparam logic [7:0] PERF_HI_OFS = 8'h08;
  localparam logic [7:0] SIB_CFG_OFS = 8'h0C;

  // control register fields
  localparam int CTRL_SSTEP_BIT = 0;
  localparam int CTRL_LBR_BIT = 1;
  localparam int CTRL_FAR_FILTER_BIT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0103;

  // state register fields
  localparam int STATE_IN_ENCL_BIT = 0;
  localparam int STATE_OPT_IN_BIT = 1;
  localparam int STATE_SUPPRESS_BIT = 2;

  // perf_global_status bit 60 lives in the upper word at bit 28
  localparam int PERF_FLAG_BIT = 28;

  // sibling counter qualifier width and reset
  localparam int SIB_CNT = 4;
  localparam logic [SIB_CNT-1:0] SIB_RESET = 4'h0;

  // trap opcodes, vectors and event type
  localparam logic [7:0] OPC_DEBUG_TRAP = 8'hF1;
  localparam logic [7:0] OPC_BREAKPOINT = 8'hCC;
  localparam logic [7:0] VEC_DEBUG = 8'h01;
  localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
  localparam logic [7:0] VEC_INVALID_OP = 8'h06;
  localparam logic [2:0] EVT_HW_EXCEPTION = 3'h3;
  localparam logic [3:0] INSN_LEN_ZERO = 4'h0;

  // branch source slot predicted marker
  localparam int PRED_BIT = 63;

  // enclave leaf classes for data breakpoint gating
  typedef enum logic [2:0] {
    LEAF_NONE = 3'h0,
    LEAF_MGMT = 3'h1,
    LEAF_ENTER = 3'h2,
    LEAF_KEY = 3'h3,
    LEAF_REPORT = 3'h4
  } leaf_t;

  // record sequencer, gray along idle -> second push
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_EVENT = 2'b01
  } seq_t;

  // one branch record
  typedef struct packed {
    logic valid;
    logic non_tx;
    logic [63:0] src;
    logic [63:0] dst;
  } branch_rec_t;

  // one trap exception report
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic [2:0] evt_type;
    logic [3:0] insn_len;
    logic [63:0] ssa_ip;
    logic [63:0] stack_ip;
  } trap_rep_t;

endpackage

// ---- trap_opcode_map.sv ----
// maps one-byte trap opcodes inside an enclave to fault vectors
`timescale 1ns/10ps
module trap_opcode_map
  import enclave_gate_pkg::*;
(
  input wire logic [7:0] opcode, // retired opcode byte
  input wire logic opt_in, // latched entry class
  output logic is_trap, // opcode is one of the two traps
  output logic [7:0] vector // exception vector to raise
);

  // opt-out hides both traps behind the invalid-opcode fault
  always_comb begin
    is_trap = (opcode == OPC_DEBUG_TRAP) || (opcode == OPC_BREAKPOINT);
    vector = VEC_INVALID_OP;
    if (opt_in && opcode == OPC_DEBUG_TRAP) begin
      vector = VEC_DEBUG;
    end else if (opt_in && opcode == OPC_BREAKPOINT) begin
      vector = VEC_BREAKPOINT;
    end
  end

endmodule // trap_opcode_map

// ---- enclave_event_model.sv ----
// behavioural core event source that drives the gating block's event inputs
`timescale 1ns/10ps
module enclave_event_model
  import enclave_gate_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic go, // request from the bench
  input wire logic [3:0] kind, // request code
  input wire logic [7:0] arg, // opcode or access qualifiers
  output logic entry_valid, // entry retired
  output logic entry_is_resume, // resume entry
  output logic debug_opt_in_flag, // entry class flag
  output logic [63:0] entry_ip, // entry address
  output logic [63:0] entry_dest, // entry target
  output logic sync_exit_valid, // sync exit retired
  output logic [63:0] sync_exit_ip, // exit address
  output logic [63:0] sync_exit_dest, // exit target
  output logic async_exit_valid, // async exit done
  output logic [63:0] state_save_ip, // saved ip
  output logic [63:0] landing_point, // landing point
  output logic event_pushes_rec, // event records a branch
  output logic [63:0] event_target, // event target
  output logic branch_valid, // inner branch
  output logic [63:0] branch_src, // branch source
  output logic [63:0] branch_dst, // branch target
  output logic access_valid, // access checked
  output logic access_implicit, // implicit access
  output logic access_protected, // protected operand
  output leaf_t access_leaf, // leaf class
  output logic access_raw_hit, // raw address match
  output logic opcode_valid, // opcode retired
  output logic [7:0] opcode, // opcode byte
  output logic [63:0] opcode_ip // opcode address
);
  logic v_q;
  logic [3:0] k_q;
  logic [7:0] a_q;
  // idle buses show the inverse so stale values never look valid
  function automatic logic [63:0] hold(input logic v, input logic [63:0] x);
    return v ? x : ~x;
  endfunction
  // one request becomes a one-cycle pulse
  always_ff @(posedge sys_clk) begin
    v_q <= go;
    k_q <= kind;
    a_q <= arg;
  end
  // codes 0..3 are entries: bit0 resume, bit1 opt-out
  assign entry_valid = v_q && (k_q < 4'h4);
  assign entry_is_resume = k_q[0];
  assign debug_opt_in_flag = ~k_q[1];
  assign entry_ip = hold(entry_valid, 64'h1000);
  assign entry_dest = hold(entry_valid, 64'h2000);
  assign sync_exit_valid = v_q && (k_q == 4'h4);
  assign sync_exit_ip = hold(sync_exit_valid, 64'h3000);
  assign sync_exit_dest = hold(sync_exit_valid, 64'h4000);
  assign async_exit_valid = v_q && (k_q == 4'h5);
  assign state_save_ip = hold(async_exit_valid, 64'h5000);
  // landing point is a static level held by the core
  assign landing_point = 64'h6000;
  // arg bit 0 set means the causing event leaves no record of its own
  assign event_pushes_rec = ~a_q[0];
  assign event_target = hold(async_exit_valid, 64'h7000);
  assign opcode_valid = v_q && (k_q == 4'h6);
  assign opcode = a_q;
  assign opcode_ip = hold(opcode_valid, 64'h8000);
  assign access_valid = v_q && (k_q == 4'h7);
  assign access_implicit = a_q[0];
  assign access_protected = a_q[1];
  assign access_leaf = leaf_t'(a_q[4:2]);
  assign access_raw_hit = 1'b1;
  assign branch_valid = v_q && (k_q == 4'h8);
  assign branch_src = hold(branch_valid, 64'h9000);
  assign branch_dst = hold(branch_valid, 64'hA000);
endmodule // enclave_event_model

// ---- test_enclave_debug_trace_gating.sv ----
// self-checking bench for the enclave debug and trace gating block
`timescale 1ns/10ps
module test_enclave_debug_trace_gating;
  import enclave_gate_pkg::*;
  localparam logic [63:0] P = 64'h8000_0000_0000_0000;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, go, er;
  logic [7:0] paddr, arg, opcode;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] kind;
  logic entry_valid, entry_is_resume, debug_opt_in_flag, sync_exit_valid;
  logic async_exit_valid, event_pushes_rec, branch_valid, access_valid;
  logic access_implicit, access_protected, access_raw_hit, opcode_valid;
  logic sibling_opt_out, bp_match, single_step_trap, own_opt_out;
  logic fixed0_run, pmc_run, precise_event_sampling_run, fixed12_run;
  logic [63:0] entry_ip, entry_dest, sync_exit_ip, sync_exit_dest;
  logic [63:0] state_save_ip, landing_point, event_target, opcode_ip;
  logic [63:0] branch_src, branch_dst;
  logic [SIB_CNT-1:0] count_both_threads;
  leaf_t access_leaf;
  trap_rep_t trap_rep;
  branch_rec_t branch_rec;
  wire [4:0] runs = {own_opt_out, fixed0_run, pmc_run, precise_event_sampling_run, fixed12_run};
  int failures = 0;
  int n_checks = 0;
  logic [7:0] acc [6] = '{8'h0E, 8'h06, 8'h0F, 8'h10, 8'h12, 8'h0A};
  enclave_debug_trace_gating dut (.sys_clk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .entry_valid,
    .entry_is_resume, .debug_opt_in_flag, .entry_ip, .entry_dest,
    .sync_exit_valid, .sync_exit_ip, .sync_exit_dest, .async_exit_valid,
    .state_save_ip, .landing_point, .event_pushes_rec, .event_target,
    .branch_valid, .branch_src, .branch_dst, .access_valid, .access_implicit,
    .access_protected, .access_leaf, .access_raw_hit, .opcode_valid, .opcode,
    .opcode_ip, .sibling_opt_out, .bp_match, .trap_rep, .single_step_trap,
    .branch_rec, .fixed0_run, .pmc_run, .precise_event_sampling_run, .fixed12_run, .own_opt_out,
    .count_both_threads);
  enclave_event_model core (.sys_clk, .go, .kind, .arg, .entry_valid,
    .entry_is_resume, .debug_opt_in_flag, .entry_ip, .entry_dest,
    .sync_exit_valid, .sync_exit_ip, .sync_exit_dest, .async_exit_valid,
    .state_save_ip, .landing_point, .event_pushes_rec, .event_target,
    .branch_valid, .branch_src, .branch_dst, .access_valid, .access_implicit,
    .access_protected, .access_leaf, .access_raw_hit, .opcode_valid, .opcode,
    .opcode_ip);
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [143:0] got, input logic [143:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // apb transfer; waits on pready under a bound, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask
  // one event; outputs are looked at one cycle after it is taken
  task automatic ev(input logic [3:0] k, input logic [7:0] a);
    @(posedge sys_clk);
    {go, kind, arg} <= {1'b1, k, a};
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic sib(input logic v, input logic [SIB_CNT-1:0] exp);
    @(posedge sys_clk);
    sibling_opt_out <= v;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(count_both_threads, exp);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {srst, psel, penable, pwrite, go, sibling_opt_out} = 6'b100000;
    {paddr, pwdata, kind, arg} = '0;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    // reset values and an unmapped place
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, PERF_HI_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    $display("test reset done");
    // opt-in enter with single-step and recording on
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    ev(4'h0, 8'h00);
    chk(single_step_trap, 1'b1);
    chk(branch_rec, {2'b11, P | 64'h1000, 64'h2000});
    apb(1'b0, STATE_OFS, 32'h0);
    chk(rd, 32'h3);
    for (int j = 0; j < 6; j++) begin
      ev(4'h7, acc[j]);
      chk(bp_match, (j == 0) || (j == 3) || (j == 4));
    end
    ev(4'h6, OPC_BREAKPOINT);
    chk(trap_rep, {1'b1, VEC_BREAKPOINT, EVT_HW_EXCEPTION, INSN_LEN_ZERO,
      64'h8000, 64'h6000});
    ev(4'h6, OPC_DEBUG_TRAP);
    chk(trap_rep.vector, VEC_DEBUG);
    ev(4'h8, 8'h00);
    chk({branch_rec.valid, branch_rec.dst}, {1'b1, 64'hA000});
    ev(4'h4, 8'h00);
    chk(single_step_trap, 1'b1);
    chk(branch_rec, {2'b11, P | 64'h3000, 64'h4000});
    apb(1'b0, PERF_HI_OFS, 32'h0);
    chk(rd, 32'h0);
    ev(4'h1, 8'h00);
    chk(single_step_trap, 1'b0);
    chk(branch_rec, {2'b11, P | 64'h1000, 64'h2000});
    ev(4'h5, 8'h00);
    chk(single_step_trap, 1'b0);
    chk(branch_rec, {2'b11, P | 64'h5000, 64'h6000});
    $display("test opt_in done");
    // opt-out resume: suppression, counters, traps
    ev(4'h3, 8'h00);
    chk({single_step_trap, branch_rec.valid}, 2'b00);
    chk(runs, 5'h11);
    apb(1'b0, PERF_HI_OFS, 32'h0);
    chk(rd, 32'h1000_0000);
    apb(1'b0, STATE_OFS, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, SIB_CFG_OFS, 32'h0000_000F);
    sib(1'b1, 4'h0);
    sib(1'b0, 4'hF);
    ev(4'h8, 8'h00);
    chk(branch_rec.valid, 1'b0);
    ev(4'h6, OPC_DEBUG_TRAP);
    chk({trap_rep.valid, trap_rep.vector}, {1'b1, VEC_INVALID_OP});
    ev(4'h7, acc[0]);
    chk(bp_match, 1'b0);
    ev(4'h5, 8'h00);
    chk(branch_rec, {2'b11, P | 64'h1000, 64'h6000});
    @(posedge sys_clk);
    #1;
    chk(branch_rec, {2'b10, 64'h6000, 64'h7000});
    chk(runs, 5'h0F);
    // opt-out enter then sync exit gives one record
    ev(4'h2, 8'h00);
    ev(4'h4, 8'h00);
    chk(single_step_trap, 1'b1);
    chk(branch_rec, {2'b11, P | 64'h1000, 64'h4000});
    apb(1'b1, PERF_HI_OFS, 32'h1000_0000);
    apb(1'b0, PERF_HI_OFS, 32'h0);
    chk(rd, 32'h0);
    // opt-out stay whose ending event leaves no record of its own
    ev(4'h2, 8'h00);
    ev(4'h5, 8'h01);
    chk(branch_rec, {2'b11, P | 64'h1000, 64'h6000});
    @(posedge sys_clk);
    #1;
    chk(branch_rec.valid, 1'b0);
    // a mid-run reset drops a stay in progress
    ev(4'h2, 8'h00);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    apb(1'b0, STATE_OFS, 32'h0);
    chk(rd, 32'h0);
    chk(runs, 5'h0F);
    apb(1'b0, PERF_HI_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("test opt_out done");
    // far filter drops transition records
    apb(1'b1, CTRL_OFS, 32'h0000_0103);
    ev(4'h0, 8'h00);
    chk(branch_rec.valid, 1'b0);
    ev(4'h4, 8'h00);
    chk(branch_rec.valid, 1'b0);
    $display("test filter done");
    test_done();
  end
endmodule // test_enclave_debug_trace_gating
